// >>> hbp_pkg.sv
/*
 * Constants and types for the H-bridge protection and sleep supervisor.
 * Assumes a 100 MHz system clock; times are kept in their own units.
 */
`default_nettype none
package hbp_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int BLANK_NS = 3750;
    localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int PWM_KHZ = 50;
    localparam int PWM_CYC = (CLK_MHZ * 1000) / PWM_KHZ;
    localparam int WAKE_US = 1000;
    localparam int WAKE_CYC_DEF = WAKE_US * CLK_MHZ;
    localparam int OC_QUAL_NS = 3000;
    localparam int OC_QUAL_CYC = (OC_QUAL_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 17;
    localparam int NUM_BR = 2;

    // ----------------------------------------
    // Top-level state
    // ----------------------------------------
    typedef enum logic [3:0] {
        HBP_RESET = 4'b0001,
        HBP_SLEEP = 4'b0010,
        HBP_WAKE  = 4'b0100,
        HBP_RUN   = 4'b1000
    } hbp_state_t;
endpackage
`default_nettype wire

// >>> hbp_supervisor.sv
/*
 * Supervisor for a dual H-bridge driver: blanking, chopping, reset,
 * sleep and wake, overcurrent, thermal and undervoltage handling.
 * Assumes pin inputs are asynchronous and are synchronised here;
 * analog comparators deliver clean levels on their own inputs.
 */
// How it works
// R1: Ignore sense input 3.75 us after turn-on
// R2: Blanking window is minimum PWM on-time
// R3: Logic reset clears state, disables both bridges
// R4: All control inputs ignored during logic reset
// R5: Sleep disables bridges, pump, regulator, clocks
// R6: Control inputs ignored while sleep held low
// R7: About 1 ms wake settling before operation
// R8: Qualified current limit disables bridge, fault low
// R9: Overcurrent shutdown latched until reset or supply
// R10: High-side or low-side limit trips shutdown
// R11: Overcurrent path independent of chopping sense
// R12: Over-temperature disables bridges, fault low
// R13: Thermal shutdown recovers on its own
// R14: Undervoltage disables everything, holds logic reset
// R15: Undervoltage clear resumes operation automatically
// R16: Chopping trip holds bridge off until next cycle
// R17: Fault output released when no fault remains
`timescale 1ns/1ps
`default_nettype none
module hbp_supervisor
    import hbp_pkg::*;
#(
    parameter int WAKE_CYC = WAKE_CYC_DEF
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Host control pins
    input wire logic logic_reset_low_in,
    input wire logic sleep_request_low_in,
    input wire logic [1:0] bridge_enable_in,
    // Analog indications
    input wire logic [1:0] current_sense_input_in,
    input wire logic [1:0] hs_limit_in,
    input wire logic [1:0] ls_limit_in,
    input wire logic thermal_trip_in,
    input wire logic supply_undervoltage_lockout_in,
    // Outputs
    output logic [1:0] bridge_drive_out,
    output logic charge_pump_on_out,
    output logic aux_regulator_output_out,
    output logic clocks_run_out,
    output logic ready_out,
    output logic [1:0] overcurrent_trip_out,
    output logic fault_flag_low_out
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Two stages on every pin; only the second stage is read below
    logic [9:0] s1_r, s2_r;
    logic [9:0] pins;
    assign pins = {logic_reset_low_in, sleep_request_low_in, bridge_enable_in,
                   current_sense_input_in, hs_limit_in | ls_limit_in,
                   thermal_trip_in, supply_undervoltage_lockout_in};
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            s1_r <= 10'h0;
            s2_r <= 10'h0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
        end
    end
    logic rst_n, slp_n, hot, low_supply;
    logic [1:0] en, sense, ilim;
    assign rst_n = s2_r[9];
    assign slp_n = s2_r[8];
    assign en = s2_r[7:6];
    assign sense = s2_r[5:4];
    assign ilim = s2_r[3:2]; // R10 R11
    assign hot = s2_r[1];
    assign low_supply = s2_r[0];

    function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v, input int lim);
        inc_sat = (v >= CNT_W'(lim)) ? v : v + CNT_W'(1);
    endfunction

    // ----------------------------------------
    // Mode state machine
    // ----------------------------------------
    hbp_state_t st_r, st_nxt;
    logic [CNT_W-1:0] wake_r, wake_nxt;
    logic hold_rst;
    assign hold_rst = !rst_n || low_supply; // R3 R14
    always_comb begin
        st_nxt = st_r;
        wake_nxt = wake_r;
        case (st_r)
            HBP_RESET: begin
                if (!hold_rst) st_nxt = slp_n ? HBP_RUN : HBP_SLEEP; // R15
            end
            HBP_SLEEP: begin
                wake_nxt = '0;
                if (slp_n) st_nxt = HBP_WAKE; // R6
            end
            HBP_WAKE: begin
                wake_nxt = inc_sat(wake_r, WAKE_CYC);
                if (!slp_n) st_nxt = HBP_SLEEP;
                else if (wake_r >= CNT_W'(WAKE_CYC - 1)) st_nxt = HBP_RUN; // R7
            end
            HBP_RUN: begin
                if (!slp_n) st_nxt = HBP_SLEEP; // R5
            end
            default: st_nxt = HBP_RESET;
        endcase
        if (hold_rst) begin
            st_nxt = HBP_RESET; // R4 R14
            wake_nxt = '0;
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            st_r <= HBP_RESET;
            wake_r <= '0;
        end else begin
            st_r <= st_nxt;
            wake_r <= wake_nxt;
        end
    end

    // ----------------------------------------
    // PWM period, blanking, overcurrent per bridge
    // ----------------------------------------
    // One shared period counter; the chop latch is released at its wrap
    logic [CNT_W-1:0] per_r, per_nxt;
    logic [CNT_W-1:0] blk_r [NUM_BR], blk_nxt [NUM_BR];
    logic [CNT_W-1:0] ocq_r [NUM_BR], ocq_nxt [NUM_BR];
    logic [1:0] chop_r, chop_nxt, oc_r, oc_nxt, on_r, on_nxt;
    logic run, wrap;
    assign run = (st_r == HBP_RUN) && !hold_rst && slp_n;
    assign wrap = (per_r == CNT_W'(PWM_CYC - 1));
    always_comb begin
        per_nxt = wrap ? '0 : per_r + CNT_W'(1);
        chop_nxt = chop_r;
        oc_nxt = oc_r;
        on_nxt = on_r;
        for (int b = 0; b < NUM_BR; b++) begin
            blk_nxt[b] = blk_r[b];
            ocq_nxt[b] = ilim[b] ? inc_sat(ocq_r[b], OC_QUAL_CYC) : '0;
            if (ocq_r[b] >= CNT_W'(OC_QUAL_CYC)) oc_nxt[b] = 1'b1; // R8 R9
            on_nxt[b] = run && en[b] && !oc_r[b] && !hot && !chop_r[b];
            if (!on_r[b]) blk_nxt[b] = '0; // R1
            else blk_nxt[b] = inc_sat(blk_r[b], BLANK_CYC);
            // Sense only acts once blanking has expired, so on-time >= blank
            if (on_r[b] && sense[b] && blk_r[b] >= CNT_W'(BLANK_CYC)) chop_nxt[b] = 1'b1; // R1 R2 R16
            if (wrap) chop_nxt[b] = 1'b0; // R16
        end
        if (hold_rst) begin
            chop_nxt = '0; // R3
            oc_nxt = '0; // R9
            on_nxt = '0;
            // Qualifier cleared too, so no trip is latched while held
            for (int b = 0; b < NUM_BR; b++) begin
                ocq_nxt[b] = '0; // R3
            end
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            per_r <= '0;
            chop_r <= '0;
            oc_r <= '0;
            on_r <= '0;
            for (int b = 0; b < NUM_BR; b++) begin
                blk_r[b] <= '0;
                ocq_r[b] <= '0;
            end
        end else begin
            per_r <= per_nxt;
            chop_r <= chop_nxt;
            oc_r <= oc_nxt;
            on_r <= on_nxt;
            for (int b = 0; b < NUM_BR; b++) begin
                blk_r[b] <= blk_nxt[b];
                ocq_r[b] <= ocq_nxt[b];
            end
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    logic pwr_on, flt_nxt;
    assign pwr_on = !hold_rst && (st_nxt != HBP_SLEEP) && (st_nxt != HBP_RESET);
    assign flt_nxt = !((|oc_nxt) || hot); // R12 R13 R17
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            bridge_drive_out <= 2'h0;
            charge_pump_on_out <= 1'b0;
            aux_regulator_output_out <= 1'b0;
            clocks_run_out <= 1'b0;
            ready_out <= 1'b0;
            overcurrent_trip_out <= 2'h0;
            fault_flag_low_out <= 1'b1;
        end else begin
            bridge_drive_out <= on_nxt; // R3 R5 R8 R12
            charge_pump_on_out <= pwr_on; // R5
            aux_regulator_output_out <= pwr_on; // R5
            clocks_run_out <= pwr_on; // R5
            ready_out <= (st_nxt == HBP_RUN);
            overcurrent_trip_out <= oc_nxt;
            fault_flag_low_out <= flt_nxt; // R17
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_reset_off;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        hold_rst |=> bridge_drive_out == 2'h0;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("bridge driven in reset"); // R3
    property p_reset_state;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (hold_rst && en != 2'h0) |=> st_r == HBP_RESET && !ready_out;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("inputs obeyed in reset"); // R4
    property p_sleep_off;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (st_r == HBP_SLEEP && !hold_rst && !slp_n)
            |=> !charge_pump_on_out && !aux_regulator_output_out && !clocks_run_out;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("power on in sleep"); // R5
    property p_sleep_ign;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (st_r == HBP_SLEEP && !slp_n) |=> bridge_drive_out == 2'h0;
    endproperty
    a_sleep_ign: assert property (p_sleep_ign) else $error("drive in sleep"); // R6
    property p_wake_wait;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (st_r == HBP_WAKE && wake_r < CNT_W'(WAKE_CYC - 1)) |=> st_r != HBP_RUN;
    endproperty
    a_wake_wait: assert property (p_wake_wait) else $error("woke too early"); // R7
    property p_oc_trip;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (ocq_r[0] >= CNT_W'(OC_QUAL_CYC) && !hold_rst)
            |=> oc_r[0] && !fault_flag_low_out ##1 !bridge_drive_out[0];
    endproperty
    a_oc_trip: assert property (p_oc_trip) else $error("overcurrent not handled"); // R8
    property p_oc_latch;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (oc_r[1] && !hold_rst) |=> oc_r[1];
    endproperty
    a_oc_latch: assert property (p_oc_latch) else $error("overcurrent unlatched"); // R9
    property p_thermal;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        hot |=> !fault_flag_low_out && bridge_drive_out == 2'h0;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal not handled"); // R12
    property p_therm_resume;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (st_r == HBP_RUN && slp_n && !hold_rst && !hot && en == 2'h3 && oc_r == 2'h0 && chop_r == 2'h0)
            |=> bridge_drive_out == 2'h3;
    endproperty
    a_therm_resume: assert property (p_therm_resume) else $error("no resume after thermal"); // R13
    property p_blank;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        $rose(on_r[0]) |=> !chop_r[0] [*8];
    endproperty
    a_blank: assert property (p_blank) else $error("chop inside blanking"); // R1
    property p_min_on;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (on_r[0] && blk_r[0] < CNT_W'(BLANK_CYC)) |=> !$rose(chop_r[0]);
    endproperty
    a_min_on: assert property (p_min_on) else $error("on-time below blanking"); // R2
    property p_chop_hold;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (chop_r[0] && !wrap && !hold_rst) |=> chop_r[0] && !bridge_drive_out[0];
    endproperty
    a_chop_hold: assert property (p_chop_hold) else $error("chop released early"); // R16
    property p_uv_off;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        low_supply |=> bridge_drive_out == 2'h0 && !charge_pump_on_out && !ready_out && st_r == HBP_RESET;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("active in undervoltage"); // R14
    property p_run_after;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (st_r == HBP_RESET && !hold_rst && slp_n) |=> ready_out;
    endproperty
    a_run_after: assert property (p_run_after) else $error("no resume after reset"); // R15
    property p_sleep_stay;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (st_r == HBP_SLEEP && !slp_n) |=> st_r != HBP_RUN && !ready_out;
    endproperty
    a_sleep_stay: assert property (p_sleep_stay) else $error("left sleep early"); // R6
    property p_flt_rel;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (!hot && (hold_rst || (oc_r == 2'h0 && ocq_r[0] < CNT_W'(OC_QUAL_CYC) && ocq_r[1] < CNT_W'(OC_QUAL_CYC))))
            |=> fault_flag_low_out;
    endproperty
    a_flt_rel: assert property (p_flt_rel) else $error("fault not released"); // R17

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    c_chop: cover property (@(posedge clk_sys_in) $rose(chop_r[0]));
    c_oc: cover property (@(posedge clk_sys_in) $rose(oc_r[1]));
    c_wake: cover property (@(posedge clk_sys_in) st_r == HBP_WAKE ##1 st_r == HBP_RUN);
    c_resume: cover property (@(posedge clk_sys_in) $fell(hot) ##1 bridge_drive_out != 2'h0);
endmodule
`default_nettype wire

// >>> hbp_host.sv
/*
 * Host controller model for the supervisor's parallel control pins.
 * Assumes the bench sets its wishes and feeds back the ready level.
 */
`timescale 1ns/1ps
`default_nettype none
module hbp_host (
    // Clock
    input wire logic clk_sys_in,
    // Wishes from the bench
    input wire logic rst_req_in,
    input wire logic sleep_req_in,
    input wire logic [1:0] en_req_in,
    input wire logic rude_in,
    input wire logic ready_in,
    // Control pins
    output logic logic_reset_low_out,
    output logic sleep_request_low_out,
    output logic [1:0] bridge_enable_out
);
    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    // No motion until wake has settled, unless told to misbehave
    always @(posedge clk_sys_in) begin
        logic_reset_low_out <= !rst_req_in;
        sleep_request_low_out <= !sleep_req_in;
        bridge_enable_out <= (ready_in === 1'b1 || rude_in) ? en_req_in : 2'h0;
    end
endmodule
`default_nettype wire

// >>> hbridge_protection_sleep_control_bench.sv
/*
 * Self-checking bench for the supervisor with a host model.
 * Assumes WAKE_CYC shortened to 50 and a 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module hbridge_protection_sleep_control_bench;
    import hbp_pkg::*;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic rst_req = 1'b0, sleep_req = 1'b0, rude = 1'b0, therm = 1'b0, uv = 1'b0;
    logic [1:0] en_req = 2'h0, sense = 2'h0, hs = 2'h0, ls = 2'h0;
    logic rst_l, slp_l, ready, pump, aux, clks, fault_l;
    logic [1:0] en, drive, oc;
    int err_count = 0;
    int check_count = 0;

    always #5 clk_sys_in = ~clk_sys_in;

    hbp_host u_hbp_host (.clk_sys_in(clk_sys_in), .rst_req_in(rst_req), .sleep_req_in(sleep_req),
        .en_req_in(en_req), .rude_in(rude), .ready_in(ready), .logic_reset_low_out(rst_l),
        .sleep_request_low_out(slp_l), .bridge_enable_out(en));
    hbp_supervisor #(.WAKE_CYC(50)) u_hbp_supervisor (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .logic_reset_low_in(rst_l), .sleep_request_low_in(slp_l), .bridge_enable_in(en),
        .current_sense_input_in(sense), .hs_limit_in(hs), .ls_limit_in(ls), .thermal_trip_in(therm),
        .supply_undervoltage_lockout_in(uv), .bridge_drive_out(drive), .charge_pump_on_out(pump),
        .aux_regulator_output_out(aux), .clocks_run_out(clks), .ready_out(ready),
        .overcurrent_trip_out(oc), .fault_flag_low_out(fault_l));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [1:0] exp_drive(input logic [1:0] e, input logic off);
        return off ? 2'h0 : e;
    endfunction
    function automatic logic exp_fault(input logic [1:0] o, input logic t);
        return !((|o) || t);
    endfunction
    task automatic at(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        #1;
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Bounded wait on ready (sel 0) or bridge 0 drive (sel 1)
    function automatic logic pick(input int sel);
        return (sel == 0) ? ready : drive[0];
    endfunction
    task automatic wait_for(input int sel, input logic lvl, input int lim);
        int i;
        i = 0;
        while (pick(sel) !== lvl && i < lim) begin
            at(1);
            i++;
        end
        if (pick(sel) !== lvl) begin
            err_count++;
            close_out();
        end
    endtask

    initial begin
        at(60000);
        err_count++;
        close_out();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'h558B));
        at(12);
        sys_rst_in <= 1'b0;
        wait_for(0, 1'b1, 200);
        chk({pump, aux, clks, fault_l}, 4'hF);
        repeat (20) begin
            at(1);
            en_req <= 2'($urandom);
            at(8);
            chk(drive, exp_drive(en_req, 1'b0));
        end
        at(1);
        en_req <= 2'h0;
        at(8);
        en_req <= 2'h1;
        sense <= 2'h1;
        at(300);
        chk(drive[0], 1'b1);
        at(92);
        chk(drive[0], 1'b0);
        at(1);
        sense <= 2'h0;
        at(100);
        chk(drive[0], 1'b0);
        wait_for(1, 1'b1, PWM_CYC + 10);
        at(1);
        en_req <= 2'h3;
        hs <= 2'h2;
        at(OC_QUAL_CYC + 20);
        chk({oc, drive[1], fault_l}, {2'h2, 1'b0, exp_fault(2'h2, 1'b0)});
        at(1);
        hs <= 2'h0;
        ls <= 2'h1;
        at(OC_QUAL_CYC + 20);
        chk({oc, drive}, {2'h3, 2'h0});
        at(1);
        ls <= 2'h0;
        rst_req <= 1'b1;
        rude <= 1'b1;
        at(10);
        chk({ready, oc, drive, fault_l}, {1'b0, 2'h0, 2'h0, 1'b1});
        at(1);
        rst_req <= 1'b0;
        wait_for(0, 1'b1, 200);
        at(8);
        chk(drive, 2'h3);
        at(1);
        therm <= 1'b1;
        at(6);
        chk({drive, fault_l}, {2'h0, exp_fault(2'h0, 1'b1)});
        at(1);
        therm <= 1'b0;
        at(8);
        chk({drive, fault_l}, {2'h3, 1'b1});
        at(1);
        uv <= 1'b1;
        at(6);
        chk({ready, pump, drive}, 4'h0);
        at(1);
        uv <= 1'b0;
        wait_for(0, 1'b1, 200);
        at(8);
        chk(drive, 2'h3);
        at(1);
        sleep_req <= 1'b1;
        at(6);
        chk({pump, aux, clks, drive}, 5'h00);
        at(1);
        en_req <= 2'h1;
        at(10);
        chk({ready, drive}, 3'h0);
        at(1);
        sleep_req <= 1'b0;
        rude <= 1'b0;
        en_req <= 2'h3;
        at(52);
        chk({ready, drive}, 3'h0);
        wait_for(0, 1'b1, 8);
        at(8);
        chk(drive, 2'h3);
        close_out();
    end
endmodule
`default_nettype wire
